// File: dv/mbi_cpu_model.sv
// host processor model on the multiplexed bus
`timescale 1ns/100ps
module mbi_cpu_model
  import mbi_pkg::*;
(
  // clock
  input  wire logic              sys_clk_i,
  // device side of the shared lines
  input  wire logic [DATA_W-1:0] dev_data_i,
  input  wire logic              dev_oe_i,
  // lines toward the device
  output logic [DATA_W-1:0]      bus_o,
  output logic                   ale_o,
  output logic                   sel_o,
  output logic                   rd_n_o,
  output logic                   wr_o
);
  logic [DATA_W-1:0] ad_ff;
  logic              drv_ff;
  logic              sel_tied;  // split mode with select wired high

  // released lines show the inverse of the last value
  assign bus_o = dev_oe_i ? dev_data_i : (drv_ff ? ad_ff : ~ad_ff);

  initial begin
    ale_o  = 1'b0;
    sel_o  = 1'b0;
    rd_n_o = 1'b1;
    wr_o   = 1'b1;
    ad_ff  = 8'h00;
    drv_ff = 1'b1;
    sel_tied = 1'b0;
  end

  // one byte access; e_mode picks the strobe-qualified protocol
  task automatic access(input logic e_mode, input logic is_rd, input logic cs,
                        input logic [7:0] addr, input logic [7:0] wdat, output logic [7:0] rdat);
    @(negedge sys_clk_i);
    sel_o  = sel_tied;                // mode set with select at sel_tied, low unless wired high
    rd_n_o = !e_mode;                 // read strobe tied low in E mode
    wr_o   = 1'b1;
    ad_ff  = addr;
    drv_ff = 1'b1;
    ale_o  = 1'b1;                    // address under latch strobe
    @(negedge sys_clk_i);
    ale_o  = 1'b0;                    // address held past the fall
    @(negedge sys_clk_i);
    sel_o  = cs;                      // select or E from cs inside the access; sel_tied outside it
    if (is_rd) begin
      drv_ff = 1'b0;                  // lines floated for a read
      rd_n_o = 1'b0;
    end else begin
      ad_ff  = wdat;
      wr_o   = 1'b0;
    end
    repeat (2) @(negedge sys_clk_i);  // command or E held two cycles
    rdat   = bus_o;
    sel_o  = sel_tied;                // close by select and command
    rd_n_o = !e_mode;
    wr_o   = 1'b1;
  endtask
endmodule // mbi_cpu_model

// File: dv/mbi_host_port_sva.sv
// pin-level assertions for the host port
`timescale 1ns/100ps
module mbi_host_port_sva
  import mbi_pkg::*;
(
  // clock and reset
  input wire logic              sys_clk_i,
  input wire logic              sys_rst_i,
  // host pins
  input wire logic [DATA_W-1:0] addr_data_line_i,
  input wire logic              addr_data_line_oe_o,
  input wire logic              ale_i,
  input wire logic              sel_i,
  input wire logic              rd_n_i,
  input wire logic              wr_i,
  // device outputs
  input wire logic              irq_n_o,
  input wire logic              irq_n_oe_o,
  input wire logic              buffered_clock_out_en_o,
  input wire logic              core_rst_o,
  input wire logic [DATA_W-1:0] command_control_o
);
  logic [7:0] lat_ff;
  logic       ale_ff;
  logic       acc_ff;
  logic       acc;

  // ==========================================================
  // helper: latched address and access history
  assign acc = sel_i && !(rd_n_i && wr_i);
  always_ff @(posedge sys_clk_i) begin
    ale_ff <= ale_i;
    acc_ff <= acc;
    if (ale_ff && !ale_i) begin
      lat_ff <= addr_data_line_i;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  // ==========================================================
  // assertions
  a_read_drive: assert property (
    addr_data_line_oe_o == (sel_i && !rd_n_i && wr_i && !core_rst_o)) else $error("read drive mismatch");
  a_write_no_drive: assert property (
    (!sel_i || !wr_i) |-> !addr_data_line_oe_o) else $error("lines driven outside a read");
  a_rst_release: assert property (
    $fell(sys_rst_i) |-> core_rst_o [*8] ##[1:8] !core_rst_o) else $error("reset release timing wrong");
  a_clk_gate: assert property (
    buffered_clock_out_en_o == !core_rst_o) else $error("clock out gating wrong");
  a_soft_reset: assert property (
    $rose(command_control_o[CMD_SOFT_RESET_BIT]) |-> ##[0:1] core_rst_o) else $error("soft reset missed");
  a_rst_clears: assert property (
    $rose(core_rst_o) |=> command_control_o == 8'h00) else $error("command not cleared");
  a_irq_release: assert property (
    acc && !acc_ff && (lat_ff inside {[8'h08:8'h0b]}) && irq_n_oe_o |-> ##[0:3] !irq_n_oe_o)
    else $error("interrupt not released");
  a_irq_opendrain: assert property (
    irq_n_o == 1'b0) else $error("interrupt data not low");

  // covers
  c_read: cover property (addr_data_line_oe_o ##1 !addr_data_line_oe_o);
  c_irq_pulse: cover property (irq_n_oe_o ##1 !irq_n_oe_o ##[1:3] irq_n_oe_o);
  c_soft: cover property ($rose(command_control_o[CMD_SOFT_RESET_BIT]));
endmodule // mbi_host_port_sva

// File: dv/mbi_host_port_tb_top.sv
// self-checking bench for the muxed host port
`timescale 1ns/100ps
module mbi_host_port_tb_top
  import mbi_pkg::*;
;
  logic              sys_clk_i;
  logic              sys_rst_i;
  logic [DATA_W-1:0] bus;
  logic [DATA_W-1:0] dev_data;
  logic [DATA_W-1:0] cmd;
  logic [DATA_W-1:0] q;
  logic [DATA_W-1:0] ev [INT_BANKS];
  logic              dev_oe;
  logic              ale;
  logic              sel;
  logic              rd_n;
  logic              wr;
  logic              irq_oe;
  logic              ck_en;
  logic              core_rst;
  int                fail_count;
  int                checked;
  int                low_cnt;

  // ==========================================================
  // clock, device, host
  initial sys_clk_i = 1'b0;
  always #25 sys_clk_i = ~sys_clk_i;

  mbi_host_port DUT (.sys_clk_i, .sys_rst_i, .addr_data_line_i(bus), .addr_data_line_o(dev_data),
    .addr_data_line_oe_o(dev_oe), .ale_i(ale), .sel_i(sel), .rd_n_i(rd_n), .wr_i(wr), .irq_n_o(),
    .irq_n_oe_o(irq_oe), .event_i(ev), .buffered_clock_out_o(), .buffered_clock_out_en_o(ck_en),
    .osc_enable_o(), .core_rst_o(core_rst), .command_control_o(cmd));

  mbi_cpu_model HOST (.sys_clk_i, .dev_data_i(dev_data), .dev_oe_i(dev_oe), .bus_o(bus),
    .ale_o(ale), .sel_o(sel), .rd_n_o(rd_n), .wr_o(wr));

  // counts cycles with the interrupt released
  always @(negedge sys_clk_i) if (irq_oe === 1'b0) low_cnt++;

  // ==========================================================
  // helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic wait_run(output int n);
    n = 0;
    while (core_rst === 1'b1 && n < 40) begin
      @(negedge sys_clk_i);
      n++;
    end
    if (n >= 40) begin
      fail_count++;
      $display("FAIL %0t reset never released", $time);
      conclude();
    end
  endtask

  task automatic wr_b(input logic e, input logic [7:0] a, input logic [7:0] d);
    HOST.access(e, 1'b0, 1'b1, a, d, q);
  endtask

  task automatic rd_b(input logic e, input logic [7:0] a);
    HOST.access(e, 1'b1, 1'b1, a, 8'h00, q);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    int n;
    chk({7'h00, ck_en}, 8'h00, "clock out in reset");
    wait_run(n);
    chk(8'(n >= 10 && n <= 13), 8'h01, "release delay");
    chk({7'h00, ck_en}, 8'h01, "clock out running");
    chk(cmd, 8'h00, "command reset value");
    $display("test reset done");
  endtask

  task automatic t_regs();
    logic [7:0] a [4] = '{8'h00, 8'h05, 8'h0f, 8'h0c};
    for (int i = 0; i < 4; i++) wr_b(i[0], a[i], 8'h5a ^ a[i]);
    for (int i = 0; i < 4; i++) begin
      rd_b(!i[0], a[i]);
      chk(q, 8'h5a ^ a[i], "read back");
    end
    HOST.sel_tied = 1'b1;
    wr_b(1'b0, 8'h05, 8'h11);
    rd_b(1'b0, 8'h05);
    chk(q, 8'h11, "select tied high");
    HOST.sel_tied = 1'b0;
    HOST.access(1'b0, 1'b0, 1'b0, 8'h00, 8'hff, q);
    wr_b(1'b0, 8'h10, 8'h77);
    rd_b(1'b0, 8'h00);
    chk(q, 8'h5a, "deselected or unmapped write");
    rd_b(1'b1, 8'h10);
    chk(q, UNMAPPED_READ, "unmapped read");
    wr_b(1'b1, OFS_COMMAND_CONTROL, 8'hf0);
    rd_b(1'b0, OFS_COMMAND_CONTROL);
    chk(q, 8'hf0, "command read back");
    chk(cmd, 8'hf0, "command output");
    $display("test regs done");
  endtask

  task automatic t_irq();
    wr_b(1'b0, OFS_INT_ENABLE0, 8'h03);
    @(negedge sys_clk_i);
    ev[0] = 8'h03;
    @(negedge sys_clk_i);
    ev[0] = 8'h00;
    repeat (3) @(negedge sys_clk_i);
    chk({7'h00, irq_oe}, 8'h01, "irq pending");
    low_cnt = 0;
    wr_b(1'b1, OFS_INT_STATUS0, 8'h01);
    repeat (3) @(negedge sys_clk_i);
    chk(8'(low_cnt >= 1 && low_cnt <= 6), 8'h01, "release pulse");
    chk({7'h00, irq_oe}, 8'h01, "irq still pending");
    rd_b(1'b0, OFS_INT_STATUS0);
    chk(q, 8'h02, "status after clear");
    wr_b(1'b0, OFS_INT_STATUS0, 8'h02);
    repeat (3) @(negedge sys_clk_i);
    chk({7'h00, irq_oe}, 8'h00, "irq cleared");
    $display("test irq done");
  endtask

  task automatic t_soft();
    int n;
    wr_b(1'b0, 8'h00, 8'h3c);
    wr_b(1'b1, OFS_COMMAND_CONTROL, 8'h01);
    n = 0;
    while (core_rst !== 1'b1 && n < 4) begin
      @(negedge sys_clk_i);
      n++;
    end
    chk({7'h00, core_rst}, 8'h01, "soft reset taken");
    wait_run(n);
    chk(8'(n >= 9 && n <= 13), 8'h01, "soft release delay");
    rd_b(1'b0, 8'h00);
    chk(q, RST_REG_VALUE, "register cleared");
    chk(cmd, 8'h00, "command cleared");
    $display("test soft reset done");
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial begin
    sys_rst_i = 1'b1;
    ev[0] = 8'h00;
    ev[1] = 8'h00;
    fail_count = 0;
    checked = 0;
    low_cnt = 0;
    repeat (8) @(negedge sys_clk_i);
    sys_rst_i = 1'b0;
    t_reset();
    t_regs();
    t_irq();
    t_soft();
    conclude();
  end

  initial begin
    #2000000;
    fail_count++;
    $display("FAIL %0t run timed out", $time);
    conclude();
  end
endmodule // mbi_host_port_tb_top

bind mbi_host_port mbi_host_port_sva SVA (.sys_clk_i, .sys_rst_i, .addr_data_line_i, .addr_data_line_oe_o,
  .ale_i, .sel_i, .rd_n_i, .wr_i, .irq_n_o, .irq_n_oe_o, .buffered_clock_out_en_o, .core_rst_o,
  .command_control_o);

// File: rtl/mbi_access_decode.sv
// address latch and access type decode for the host port
`timescale 1ns/100ps
module mbi_access_decode
  import mbi_pkg::*;
(
  // clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              core_rst_i,
  // host pins
  input  wire logic [DATA_W-1:0] ad_i,
  input  wire logic              ale_i,
  input  wire logic              sel_i,
  input  wire logic              rd_n_i,
  input  wire logic              wr_i,
  // decoded access
  output logic [ADDR_W-1:0]      addr_o,
  output logic                   rd_act_o,
  output logic                   acc_start_o,
  output logic                   wr_commit_o,
  output logic [DATA_W-1:0]      wr_data_o
);

  logic              ale_q_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [DATA_W-1:0] wr_data_ff;
  mbi_acc_state_type state_ff;
  mbi_acc_state_type nxt_state;
  logic              is_rd;
  logic              is_wr;

  // access type table; select low or both strobes high does nothing
  assign is_rd = sel_i & ~rd_n_i & wr_i;                     // [R03] [R05]
  assign is_wr = sel_i & ~wr_i;                              // [R02] [R13]

  // address taken on the falling edge of the latch strobe
  always_ff @(posedge sys_clk_i) begin
    if (core_rst_i) begin
      ale_q_ff <= 1'b0;
      addr_ff  <= '0;
    end else begin
      ale_q_ff <= ale_i;
      if (ale_q_ff && !ale_i) begin
        addr_ff <= ad_i;                                     // [R01] [R04]
      end
    end
  end

  // access state
  always_comb begin
    case (1'b1)
      is_rd:   nxt_state = ACC_READ;
      is_wr:   nxt_state = ACC_WRITE;
      default: nxt_state = ACC_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (core_rst_i) begin
      state_ff   <= ACC_IDLE;
      wr_data_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      if (is_wr) begin
        wr_data_ff <= ad_i;  // last data seen before the closing edge
      end
    end
  end

  // write lands when the command or E strobe closes
  assign wr_commit_o = (state_ff == ACC_WRITE) && (nxt_state != ACC_WRITE);  // [R13]
  assign acc_start_o = (state_ff == ACC_IDLE) && (nxt_state != ACC_IDLE);
  assign rd_act_o    = is_rd;
  assign addr_o      = addr_ff;
  assign wr_data_o   = wr_data_ff;

endmodule // mbi_access_decode

// File: rtl/mbi_host_port.sv
// multiplexed host port with register bank, interrupt pin and reset
`timescale 1ns/100ps
// Notes on behaviour
// (R01) Register address is taken from the shared lines when the latch strobe falls.
// (R02) Select high, read low, write low is an E-qualified write; read high is split write.
// (R03) Select high, read low, write high reads; select low or both high is idle.
// (R04) Eight shared lines carry the address first, then the data.
// (R05) Select is active high; nothing happens while it is low.
// (R06) A lone device in split-strobe mode may have select tied high.
// (R07) E-strobe mode ties read low and never ties E high.
// (R08) Host switches protocol only while select/E is low.
// (R09) Host sets address, raises latch strobe, lowers it, holds the address.
// (R10) Host then drives data or floats lines and lowers the command.
// (R11) Host ends access by returning select and command; select may stay high.
// (R12) An external decoder raises E only while the processor's E is high.
// (R13) Timing refers to command edges in split mode, to E edges otherwise.
// (R14) One active-low open-drain interrupt pin, events chosen by enable registers.
// (R15) Any access to 0x08..0x0B briefly releases the interrupt pin.
// (R16) Clearing one interrupt with another pending gives a write-strobe long high pulse; the code gives an INT_RELEASE_LOAD pulse, one clock cycle.
// (R17) Global reset comes from the reset pin or the command reset bit at 0x03.
// (R18) Both reset sources are ored into one internal reset, asserted at once.
// (R19) Internal reset enables the oscillator and waits eight periods before release.
// (R20) Release is clocked, so without a clock reset never ends.
// (R21) Buffered clock output runs only while not in reset.
// (R22) Registers appear to the host as plain memory locations.
// (R23) Release passes a two-stage chain after the eight-cycle count.
module mbi_host_port
  import mbi_pkg::*;
(
  // clock and reset
  input  wire logic                  sys_clk_i,
  input  wire logic                  sys_rst_i,
  // multiplexed address and data lines
  input  wire logic [DATA_W-1:0]     addr_data_line_i,
  output logic [DATA_W-1:0]          addr_data_line_o,
  output logic                       addr_data_line_oe_o,
  // host strobes
  input  wire logic                  ale_i,
  input  wire logic                  sel_i,
  input  wire logic                  rd_n_i,
  input  wire logic                  wr_i,
  // open-drain interrupt pin
  output logic                       irq_n_o,
  output logic                       irq_n_oe_o,
  // events from the line controller, one bank per status register
  input  wire logic [DATA_W-1:0]     event_i [INT_BANKS],
  // clock out and core reset
  output logic                       buffered_clock_out_o,
  output logic                       buffered_clock_out_en_o,
  output logic                       osc_enable_o,
  output logic                       core_rst_o,
  // command register contents
  output logic [DATA_W-1:0]          command_control_o
);

  // ==========================================================
  // reset
  logic              core_rst;
  logic              soft_global_reset_ff;

  mbi_reset_gen u_reset (
    .sys_clk_i    (sys_clk_i),
    .sys_rst_i    (sys_rst_i),
    .soft_reset_i (soft_global_reset_ff),
    .core_rst_o   (core_rst),
    .osc_enable_o (osc_enable_o)
  );

  assign core_rst_o = core_rst;

  // ==========================================================
  // host access decode
  logic [ADDR_W-1:0] addr;
  logic              rd_act;
  logic              acc_start;
  logic              wr_commit;
  logic [DATA_W-1:0] wr_data;

  mbi_access_decode u_decode (
    .sys_clk_i   (sys_clk_i),
    .core_rst_i  (core_rst),
    .ad_i        (addr_data_line_i),
    .ale_i       (ale_i),
    .sel_i       (sel_i),
    .rd_n_i      (rd_n_i),
    .wr_i        (wr_i),
    .addr_o      (addr),
    .rd_act_o    (rd_act),
    .acc_start_o (acc_start),
    .wr_commit_o (wr_commit),
    .wr_data_o   (wr_data)
  );

  logic in_bank;
  logic in_int_range;
  logic [REG_IDX_W-1:0] idx;

  // address range checks
  assign in_bank      = (addr <= OFS_REG_LAST);
  assign in_int_range = (addr >= OFS_INT_FIRST) && (addr <= OFS_INT_LAST);
  assign idx          = addr[REG_IDX_W-1:0];

  // ==========================================================
  // general register bank
  logic [DATA_W-1:0] regs_ff [REG_COUNT];
  logic [DATA_W-1:0] int_status [INT_BANKS];
  logic [DATA_W-1:0] int_enable [INT_BANKS];
  logic [INT_BANKS-1:0] bank_pend;
  logic [INT_BANKS-1:0] bank_clear_hit;

  // plain memory locations; interrupt status entries are held below
  genvar gi;
  generate
    for (gi = 0; gi < REG_COUNT; gi++) begin : g_reg
      always_ff @(posedge sys_clk_i) begin
        if (core_rst) begin
          regs_ff[gi] <= RST_REG_VALUE;
        end else if (wr_commit && in_bank && (idx == REG_IDX_W'(gi))) begin
          regs_ff[gi] <= wr_data;                            // [R22]
        end
      end
    end
  endgenerate

  // software reset bit pulses the combined reset
  always_ff @(posedge sys_clk_i) begin
    if (core_rst) begin
      soft_global_reset_ff <= 1'b0;
    end else if (wr_commit && (addr == OFS_COMMAND_CONTROL)) begin
      soft_global_reset_ff <= wr_data[CMD_SOFT_RESET_BIT];   // [R17]
    end
  end

  assign command_control_o = regs_ff[OFS_COMMAND_CONTROL[REG_IDX_W-1:0]];

  // ==========================================================
  // interrupt status and enable banks
  generate
    for (gi = 0; gi < INT_BANKS; gi++) begin : g_int
      localparam logic [7:0] STAT_OFS = OFS_INT_STATUS0 + 8'(2 * gi);
      localparam logic [7:0] EN_OFS   = OFS_INT_ENABLE0 + 8'(2 * gi);
      logic [DATA_W-1:0] status_ff;
      logic [DATA_W-1:0] clr;
      logic              clr_hit;

      // write one to clear
      assign clr     = (wr_commit && (addr == STAT_OFS)) ? wr_data : '0;
      assign clr_hit = |(clr & status_ff);

      // new events win over a clear in the same cycle
      always_ff @(posedge sys_clk_i) begin
        if (core_rst) begin
          status_ff <= RST_REG_VALUE;
        end else begin
          status_ff <= (status_ff & ~clr) | event_i[gi];
        end
      end

      assign int_status[gi]     = status_ff;
      assign int_enable[gi]     = regs_ff[EN_OFS[REG_IDX_W-1:0]];
      assign bank_pend[gi]      = |(status_ff & regs_ff[EN_OFS[REG_IDX_W-1:0]]);  // [R14]
      assign bank_clear_hit[gi] = clr_hit;
    end
  endgenerate

  // ==========================================================
  // interrupt pin drive
  logic [3:0] release_cnt_ff;
  logic       irq_oe_ff;
  logic       pend_after_clear;
  logic       any_pend;
  logic       start_release;

  assign any_pend = |bank_pend;

  // something stays pending after a clear takes effect
  always_comb begin
    pend_after_clear = 1'b0;
    for (int b = 0; b < INT_BANKS; b++) begin
      if (|(int_status[b] & int_enable[b] & ~((wr_commit && (addr == OFS_INT_STATUS0 + 8'(2 * b))) ?
                                              wr_data : 8'h00))) begin
        pend_after_clear = 1'b1;
      end
    end
  end

  // release on any interrupt register access or a clear with others left
  assign start_release = (acc_start && in_int_range) ||                 // [R15]
                         ((|bank_clear_hit) && pend_after_clear);       // [R16]

  always_ff @(posedge sys_clk_i) begin
    if (core_rst) begin
      release_cnt_ff <= 4'h0;
    end else if (start_release) begin
      release_cnt_ff <= INT_RELEASE_LOAD;                    // [R16]
    end else if (release_cnt_ff != 4'h0) begin
      release_cnt_ff <= release_cnt_ff - 4'h1;
    end
  end

  // pull low only while pending and not in a release pulse
  always_ff @(posedge sys_clk_i) begin
    if (core_rst) begin
      irq_oe_ff <= 1'b0;
    end else begin
      irq_oe_ff <= any_pend && !start_release && (release_cnt_ff <= 4'h1);  // [R14] [R15]
    end
  end

  assign irq_n_o    = 1'b0;         // open drain only ever pulls low
  assign irq_n_oe_o = irq_oe_ff;

  // ==========================================================
  // read path
  logic [DATA_W-1:0] rd_data_ff;
  logic [DATA_W-1:0] rd_mux;

  // status entries show live state, others show stored bytes
  always_comb begin
    rd_mux = UNMAPPED_READ;
    if (in_bank) begin
      rd_mux = regs_ff[idx];
      for (int b = 0; b < INT_BANKS; b++) begin
        if (addr == OFS_INT_STATUS0 + 8'(2 * b)) begin
          rd_mux = int_status[b];
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (core_rst) begin
      rd_data_ff <= '0;
    end else begin
      rd_data_ff <= rd_mux;                                  // [R22]
    end
  end

  assign addr_data_line_o    = rd_data_ff;
  assign addr_data_line_oe_o = rd_act && !core_rst;          // [R03] [R04]

  // ==========================================================
  // buffered clock out, stopped in reset
  logic buffered_clock_out_run;

  // follows the internal reset directly, so the clock
  // starts in the very cycle that reset ends and a
  // registered enable cannot lag one cycle behind it
  assign buffered_clock_out_run = !core_rst;

  assign buffered_clock_out_en_o = buffered_clock_out_run;                                // [R21]
  assign buffered_clock_out_o    = sys_clk_i && buffered_clock_out_run;                   // [R21]

endmodule // mbi_host_port

// File: rtl/mbi_pkg.sv
// shared constants and types for the muxed host bus interface
package mbi_pkg;

  // ==========================================================
  // bus widths and register bank
  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned REG_COUNT   = 16;
  localparam int unsigned REG_IDX_W   = 4;
  localparam int unsigned INT_BANKS   = 2;

  // ==========================================================
  // register offsets
  localparam logic [7:0] OFS_COMMAND_CONTROL = 8'h03;
  localparam logic [7:0] OFS_INT_FIRST       = 8'h08;
  localparam logic [7:0] OFS_INT_LAST        = 8'h0b;
  localparam logic [7:0] OFS_INT_STATUS0     = 8'h08;  // bank n status at +2n
  localparam logic [7:0] OFS_INT_ENABLE0     = 8'h09;  // bank n enable at +2n
  localparam logic [7:0] OFS_REG_LAST        = 8'h0f;

  // ==========================================================
  // fields and reset values
  localparam int unsigned CMD_SOFT_RESET_BIT = 0;
  localparam logic [7:0]  RST_REG_VALUE      = 8'h00;
  localparam logic [7:0]  UNMAPPED_READ      = 8'h00;

  // ==========================================================
  // timing
  localparam int unsigned CLK_FREQ_KHZ       = 20000;
  localparam int unsigned STABLE_CYCLES      = 8;
  localparam int unsigned INT_RELEASE_NS     = 20;
  localparam int unsigned INT_RELEASE_RAW    = (INT_RELEASE_NS * CLK_FREQ_KHZ) / 1000000;
  localparam int unsigned INT_RELEASE_CYCLES = (INT_RELEASE_RAW < 1) ? 1 : INT_RELEASE_RAW;
  localparam logic [3:0]  STABLE_LAST        = 4'(STABLE_CYCLES - 1);
  localparam logic [3:0]  INT_RELEASE_LOAD   = 4'(INT_RELEASE_CYCLES);

  // ==========================================================
  // state types
  typedef enum logic [1:0] {
    ACC_IDLE        = 2'b00,
    ACC_READ        = 2'b01,
    ACC_WRITE       = 2'b10
  } mbi_acc_state_type;

  typedef enum logic [1:0] {
    RST_HOLD        = 2'b00,
    RST_COUNT       = 2'b01,
    RST_SYNC        = 2'b10,
    RST_RUN         = 2'b11
  } mbi_rst_state_type;

endpackage

// File: rtl/mbi_reset_gen.sv
// combined reset, stability wait and synchronous release
`timescale 1ns/100ps
module mbi_reset_gen
  import mbi_pkg::*;
(
  // clock and reset sources
  input  wire logic sys_clk_i,
  input  wire logic sys_rst_i,
  input  wire logic soft_reset_i,
  // reset results
  output logic      core_rst_o,
  output logic      osc_enable_o
);

  logic              req;
  logic [3:0]        cnt_ff;
  logic [1:0]        sync_ff;
  mbi_rst_state_type state_ff;

  // pin and command bit are ored into one request
  assign req = sys_rst_i | soft_reset_i;                     // [R17] [R18]

  // hold, count eight periods, then release through two stages
  always_ff @(posedge sys_clk_i) begin
    if (req) begin
      state_ff <= RST_HOLD;
      cnt_ff   <= 4'h0;
      sync_ff  <= 2'b11;
    end else begin
      case (state_ff)
        RST_HOLD: begin
          state_ff <= RST_COUNT;
        end
        RST_COUNT: begin
          cnt_ff <= cnt_ff + 4'h1;
          if (cnt_ff == STABLE_LAST) begin
            state_ff <= RST_SYNC;                            // [R19]
          end
        end
        RST_SYNC: begin
          sync_ff <= {sync_ff[0], 1'b0};                     // [R23]
          if (sync_ff == 2'b10) begin
            state_ff <= RST_RUN;
          end
        end
        RST_RUN: begin
          sync_ff <= 2'b00;
        end
        default: begin
          state_ff <= RST_HOLD;
        end
      endcase
    end
  end

  // assertion is immediate, release only on a clock edge
  assign core_rst_o   = req | (state_ff != RST_RUN);         // [R18] [R20]
  assign osc_enable_o = 1'b1;                                // [R19]

endmodule // mbi_reset_gen
